// ### core/seep_slave.sv
// Purpose: two-wire slave protocol engine of a 4K x 8 serial eeprom
// Assumes: serial clock and data are asynchronous pins, synchronised here
// Notes: the array is modelled in logic; write time is a parameter
//
// Overview of operation
// - data falling while clock high is start
// - data rising while clock high is stop
// - data changes only while clock low
// - acknowledge on ninth clock after bytes
// - hold data low through ack high
// - no acknowledge during internal programming
// - no master ack: release data line
// - ack control byte on type and select match
// - control byte low bit selects read/write
// - two address bytes, high first, 12 bits
// - byte write: stop starts internal write
// - page write buffers 32, commits on stop
// - only low five pointer bits increment on writes
// - poll: nak while busy, ack when done
// - current read uses last address plus one
// - random read loads pointer without writing
// - master ack sends next byte, wraps
// - write-protect high inhibits array writes
module seep_slave #(
  parameter int unsigned WRITE_CYCLES = seep_pkg::WRITE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic select_pin_bit0_i,
  input wire logic select_pin_bit1_i,
  input wire logic select_pin_bit2_i,
  input wire logic wp_i,
  output logic busy_o
);
  localparam int unsigned FW = seep_pkg::ADDR_W + seep_pkg::DATA_W;

  // two-stage synchronisers, second stage plus a history stage
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic [2:0] sel_meta_q;
  logic [2:0] sel_q;
  logic wp_meta_q;
  logic wp_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      sel_meta_q <= 3'h0;
      sel_q <= 3'h0;
      wp_meta_q <= 1'b0;
      wp_q <= 1'b0;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      sel_meta_q <= {select_pin_bit2_i, select_pin_bit1_i, select_pin_bit0_i};
      sel_q <= sel_meta_q;
      wp_meta_q <= wp_i;
      wp_q <= wp_meta_q;
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign scl_rise = scl_sync_q[1] && !scl_sync_q[2];
  assign scl_fall = !scl_sync_q[1] && scl_sync_q[2];
  // level changes of data while clock stays high are bus conditions
  assign start_det = scl_s && scl_sync_q[2] && !sda_s && sda_sync_q[2];
  assign stop_det = scl_s && scl_sync_q[2] && sda_s && !sda_sync_q[2];

  seep_pkg::seep_state_t state_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic ack_phase_q;
  logic ack_drive_q;
  logic ack_slot_q;
  logic rw_q;
  logic [11:0] ptr_q;
  logic [7:0] rd_data;
  logic [7:0] tx_q;
  logic wr_pending_q;
  logic busy_q;
  logic [31:0] wcnt_q;
  logic byte_done;
  logic [7:0] rx_byte;
  logic ctrl_match;

  // a byte completes on the rising edge of its eighth clock
  assign byte_done = scl_rise && !ack_phase_q && bit_cnt_q == 3'h0 &&
                     state_q != seep_pkg::SEEP_IDLE && state_q != seep_pkg::SEEP_RDATA;
  assign rx_byte = {shift_q[6:0], sda_s};
  assign ctrl_match = rx_byte[7:4] == seep_pkg::TYPE_CODE && rx_byte[3:1] == sel_q;

  // page buffer: entries pair pointer with data
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FW-1:0] fifo_out_data;
  logic commit_q;
  logic flush;

  assign fifo_in_valid = byte_done && state_q == seep_pkg::SEEP_WDATA && !wp_q;
  // during commit, drain into the array; otherwise the buffer holds
  assign fifo_out_ready = commit_q;
  // a start abandons an unfinished page
  assign flush = start_det && !commit_q;

  seep_fifo #(
    .WIDTH(FW),
    .DEPTH(seep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i({ptr_q, rx_byte}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  seep_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(fifo_out_valid && fifo_out_ready),
    .wr_addr_i(fifo_out_data[FW-1:seep_pkg::DATA_W]),
    .wr_data_i(fifo_out_data[seep_pkg::DATA_W-1:0]),
    .rd_addr_i(ptr_q),
    .rd_data_o(rd_data)
  );

  // protocol state
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= seep_pkg::SEEP_IDLE;
      bit_cnt_q <= seep_pkg::BIT_CNT_RST;
      shift_q <= 8'h00;
      ack_phase_q <= 1'b0;
      ack_drive_q <= 1'b0;
      ack_slot_q <= 1'b0;
      rw_q <= 1'b0;
    end
    else if (start_det)
    begin
      state_q <= seep_pkg::SEEP_CTRL;
      bit_cnt_q <= seep_pkg::BIT_CNT_RST;
      ack_phase_q <= 1'b0;
      ack_drive_q <= 1'b0;
      ack_slot_q <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q <= seep_pkg::SEEP_IDLE;
      ack_phase_q <= 1'b0;
      ack_drive_q <= 1'b0;
      ack_slot_q <= 1'b0;
    end
    else if (byte_done)
    begin
      shift_q <= rx_byte;
      ack_phase_q <= 1'b1;
      bit_cnt_q <= seep_pkg::BIT_CNT_RST;
      unique case (state_q)
        seep_pkg::SEEP_CTRL:
        begin
          rw_q <= rx_byte[0];
          // busy device stays silent; polling relies on this
          ack_drive_q <= ctrl_match && !busy_q;
        end
        seep_pkg::SEEP_ADDR_HI,
        seep_pkg::SEEP_ADDR_LO,
        seep_pkg::SEEP_WDATA:
        begin
          ack_drive_q <= !busy_q;
        end
        default:
        begin
          ack_drive_q <= 1'b0;
        end
      endcase
    end
    else if (scl_rise && !ack_phase_q && state_q != seep_pkg::SEEP_RDATA)
    begin
      shift_q <= rx_byte;
      bit_cnt_q <= bit_cnt_q - 3'h1;
    end
    else if (scl_rise && ack_slot_q && state_q == seep_pkg::SEEP_RACK)
    begin
      // nak ends the read here; an ack is acted on at the next fall
      state_q <= sda_s ? seep_pkg::SEEP_IDLE : seep_pkg::SEEP_RACK;
    end
    else if (scl_fall && ack_phase_q && !ack_slot_q)
    begin
      ack_slot_q <= 1'b1;
    end
    else if (scl_fall && ack_slot_q)
    begin
      // ack released only after the ninth clock has fallen
      ack_phase_q <= 1'b0;
      ack_drive_q <= 1'b0;
      ack_slot_q <= 1'b0;
      if (state_q == seep_pkg::SEEP_CTRL)
      begin
        if (!ack_drive_q)
        begin
          state_q <= seep_pkg::SEEP_IDLE;
        end
        else
        begin
          state_q <= rw_q ? seep_pkg::SEEP_RDATA : seep_pkg::SEEP_ADDR_HI;
        end
      end
      else if (state_q == seep_pkg::SEEP_ADDR_HI)
      begin
        state_q <= seep_pkg::SEEP_ADDR_LO;
      end
      else if (state_q == seep_pkg::SEEP_ADDR_LO)
      begin
        state_q <= seep_pkg::SEEP_WDATA;
      end
      else if (state_q == seep_pkg::SEEP_RACK && !sda_s)
      begin
        state_q <= seep_pkg::SEEP_RDATA;
      end
    end
    else if (state_q == seep_pkg::SEEP_RDATA && scl_rise)
    begin
      if (bit_cnt_q == 3'h0)
      begin
        state_q <= seep_pkg::SEEP_RACK;
        ack_phase_q <= 1'b1;
      end
      bit_cnt_q <= bit_cnt_q - 3'h1;
    end
  end

  // address pointer
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ptr_q <= seep_pkg::ADDR_RST;
    end
    else if (byte_done && state_q == seep_pkg::SEEP_ADDR_HI)
    begin
      ptr_q <= {rx_byte[3:0], ptr_q[7:0]};
    end
    else if (byte_done && state_q == seep_pkg::SEEP_ADDR_LO)
    begin
      // pointer is set even if a restart follows
      ptr_q <= {ptr_q[11:8], rx_byte};
    end
    else if (byte_done && state_q == seep_pkg::SEEP_WDATA)
    begin
      ptr_q <= {ptr_q[11:5], ptr_q[4:0] + 5'h01};
    end
    else if (state_q == seep_pkg::SEEP_RDATA && scl_rise && bit_cnt_q == 3'h0)
    begin
      ptr_q <= ptr_q + 12'h001;
    end
  end

  // transmit shifter: loaded when entering a read byte, shifted on falls
  logic load_tx_q;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      tx_q <= 8'hFF;
      load_tx_q <= 1'b0;
    end
    else
    begin
      load_tx_q <= scl_fall && ack_slot_q && (
                   (state_q == seep_pkg::SEEP_CTRL && ack_drive_q && rw_q) ||
                   (state_q == seep_pkg::SEEP_RACK && !sda_s));
      if (load_tx_q)
      begin
        tx_q <= rd_data;
      end
      else if (state_q == seep_pkg::SEEP_RDATA && scl_fall)
      begin
        tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

  // open-drain drive, registered
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sda_oe_o <= 1'b0;
    end
    else if ((state_q == seep_pkg::SEEP_RDATA || state_q == seep_pkg::SEEP_RACK) && !ack_slot_q)
    begin
      sda_oe_o <= !tx_q[7];
    end
    else
    begin
      // ack only in the ninth clock; read ack slot left released for the master
      sda_oe_o <= ack_slot_q && ack_drive_q;
    end
  end

  assign sda_o = 1'b0;

  // self-timed write: stop commits the page, counter times the cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_pending_q <= 1'b0;
      commit_q <= 1'b0;
      busy_q <= 1'b0;
      wcnt_q <= 32'h0000_0000;
    end
    else
    begin
      if (fifo_in_valid)
      begin
        wr_pending_q <= 1'b1;
      end
      else if (start_det && !commit_q)
      begin
        wr_pending_q <= 1'b0;
      end
      if (stop_det && wr_pending_q && !busy_q)
      begin
        busy_q <= 1'b1;
        commit_q <= 1'b1;
        wr_pending_q <= 1'b0;
        wcnt_q <= 32'(WRITE_CYCLES);
      end
      else if (busy_q)
      begin
        if (!fifo_out_valid)
        begin
          commit_q <= 1'b0;
        end
        if (wcnt_q <= 32'h0000_0001)
        begin
          busy_q <= 1'b0;
        end
        else
        begin
          wcnt_q <= wcnt_q - 32'h0000_0001;
        end
      end
    end
  end

  assign busy_o = busy_q;
endmodule

// ### core/seep_pkg.sv
// Purpose: shared constants for the serial eeprom two-wire slave engine
// Assumes: 250 MHz system clock, serial clock passed through a synchroniser before use
// Notes: memory is 4K x 8, page is 32 bytes
package seep_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MEM_DEPTH = 4096;
  localparam int unsigned PAGE_BYTES = 32;
  localparam int unsigned PAGE_IDX_W = 5;
  localparam int unsigned FIFO_DEPTH = 32;
  // fixed device-type code; value here is arbitrary
  localparam logic [3:0] TYPE_CODE = 4'h5;
  localparam int unsigned CLK_MHZ = 250;
  // self-timed write duration, in microseconds
  localparam int unsigned WRITE_TIME_US = 5000;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [2:0] BIT_CNT_RST = 3'h7;
  typedef enum logic [2:0] {
    SEEP_IDLE,
    SEEP_CTRL,
    SEEP_ADDR_HI,
    SEEP_ADDR_LO,
    SEEP_WDATA,
    SEEP_RDATA,
    SEEP_RACK
  } seep_state_t;
endpackage

// ### core/seep_mem.sv
// Purpose: 4K x 8 array with registered read data
// Assumes: single clock, one write and one read port
// Notes: read data appear one cycle after the address
module seep_mem (
  input wire logic ref_clk_i,
  input wire logic wr_en_i,
  input wire logic [11:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [11:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem_q [seep_pkg::MEM_DEPTH];

  always_ff @(posedge ref_clk_i)
  begin
    if (wr_en_i)
    begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule

// ### core/seep_fifo.sv
// Purpose: page buffer fifo carrying address and data to the committer
// Assumes: synchronous active-low reset
// Notes: flush empties it, used when a write is abandoned; when full,
// a push drops the oldest entry so later page bytes overwrite earlier ones
module seep_fifo #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned DEPTH = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready_o = (wr_q - rd_q) != (PW+1)'(DEPTH);
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o = buf_q[rd_q[PW-1:0]];
  assign push = in_valid_i;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      buf_q[wr_q[PW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || flush_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop || (push && !in_ready_o))
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// ### verif/seep_slave_asserts.sv
// Purpose: pin-level checks on the eeprom slave engine
// Assumes: link pins change on falling system clock edges
// Notes: pin synchronisers add a few cycles of lag
module seep_slave_asserts #(
  parameter int unsigned WRITE_CYCLES = 50
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic select_pin_bit0_i,
  input wire logic select_pin_bit1_i,
  input wire logic select_pin_bit2_i,
  input wire logic wp_i,
  input wire logic busy_o
);
  logic [31:0] busy_cnt_q;
  logic [3:0] gap_q;
  logic sda_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_start; scl_i && $fell(sda_i); endsequence
  sequence s_stop; scl_i && $rose(sda_i); endsequence
  always_ff @(posedge ref_clk_i)
    busy_cnt_q <= busy_o ? busy_cnt_q + 32'h1 : 32'h0;
  // cycles since the last stop, saturating
  always_ff @(posedge ref_clk_i)
  begin
    sda_q <= sda_i;
    if (!rst_n_i)
      gap_q <= 4'hF;
    else if (scl_i && sda_i && !sda_q)
      gap_q <= 4'h0;
    else if (gap_q != 4'hF)
      gap_q <= gap_q + 4'h1;
  end
  property p_rst_quiet;
    $rose(rst_n_i) |-> !sda_oe_o && !busy_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("output active after reset");
  property p_open_drain;
    sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data value not low");
  property p_hold_high;
    scl_i && $past(scl_i) |-> $stable(sda_oe_o);
  endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("data drive changed while clock high");
  property p_busy_mute;
    busy_o |-> !sda_oe_o;
  endproperty
  a_busy_mute: assert property (p_busy_mute)
    else $error("drive while busy");
  property p_busy_len;
    $fell(busy_o) |-> busy_cnt_q == WRITE_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write time wrong");
  property p_busy_cause;
    $rose(busy_o) |-> gap_q <= 4'h8;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("write began without stop");
  property p_stop_idle;
    s_stop |=> !sda_oe_o [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("drive after stop");
  property p_start_idle;
    s_start |=> !sda_oe_o [*8];
  endproperty
  a_start_idle: assert property (p_start_idle)
    else $error("drive after start");
endmodule

// ### verif/seep_master_model.sv
// Purpose: two-wire bus master for the eeprom slave
// Assumes: data line pulled up, clock held high between frames
// Notes: five system clocks make a quarter of the 80 ns bit
module seep_master_model (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] res_val;
  event res_ev;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick();
    repeat (5) @(negedge ref_clk_i);
  endtask
  // release data first so a repeated start sees a high line
  task automatic start();
    sda_low_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    sda_low_o = 1'b1;
    tick();
    scl_o = 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    sda_low_o = 1'b0;
    tick();
  endtask
  task automatic xbit(input logic b, output logic r);
    sda_low_o = !b;
    tick();
    scl_o = 1'b1;
    tick();
    r = sda_i;
    tick();
    scl_o = 1'b0;
    tick();
  endtask
  task automatic byte_tx(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(v[i], r);
    xbit(1'b1, r);
    res_val = {7'h00, !r};
    -> res_ev;
  endtask
  task automatic byte_rx(input logic m_ack);
    logic r;
    logic [7:0] d;
    for (int i = 0; i < 8; i++)
    begin
      xbit(1'b1, r);
      d = {d[6:0], r};
    end
    xbit(!m_ack, r);
    res_val = d;
    -> res_ev;
  endtask
endmodule

// ### verif/seep_slave_tb_top.sv
// Purpose: self-checking bench for the eeprom slave engine
// Assumes: master model drives the link, data line pulled up
// Notes: write time cut to WCYC cycles to keep the run short
module seep_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WCYC = 2000;
  typedef struct packed {logic k; logic [7:0] v;} seep_note_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] sel = 3'h0;
  logic wp = 1'b0;
  logic scl, m_low, sda_oe, busy;
  wire sda = !(m_low || sda_oe);
  int seed = 32'h8651;
  int n_mismatch = 0;
  int tests_run = 0;
  seep_note_t q[$];
  logic [7:0] mem [4096];
  logic [11:0] ptr, wptr;
  always #2 ref_clk = !ref_clk;
  seep_master_model u_m (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  seep_slave #(.WRITE_CYCLES(WCYC)) dut_u (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .select_pin_bit0_i(sel[0]),
    .select_pin_bit1_i(sel[1]), .select_pin_bit2_i(sel[2]), .wp_i(wp), .busy_o(busy));
  task automatic fail(input string w, input logic [7:0] e, input logic [7:0] g);
    n_mismatch++;
    $display("MISMATCH %s expected %h seen %h", w, e, g);
  endtask
  task automatic cmp_ack(input logic e, input logic g);
    tests_run++;
    if (g !== e)
      fail("ack", {7'h00, e}, {7'h00, g});
  endtask
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
      fail("read byte", e, g);
  endtask
  task automatic note(input logic k, input logic [7:0] v);
    q.push_back('{k, v});
  endtask
  always @(u_m.res_ev)
  begin
    seep_note_t n;
    if (q.size() == 0)
      fail("result", 8'h00, u_m.res_val);
    else
    begin
      n = q.pop_front();
      if (n.k)
        cmp_byte(n.v, u_m.res_val);
      else
        cmp_ack(n.v[0], u_m.res_val[0]);
    end
  end
  task automatic ctl(input logic rw, input logic ack);
    u_m.start();
    note(1'b0, {7'h00, ack});
    u_m.byte_tx({seep_pkg::TYPE_CODE, sel, rw});
  endtask
  task automatic set_addr(input logic [11:0] a);
    ctl(1'b0, 1'b1);
    note(1'b0, 8'h01);
    u_m.byte_tx({4'h0, a[11:8]});
    note(1'b0, 8'h01);
    u_m.byte_tx(a[7:0]);
    ptr = a;
    wptr = a;
  endtask
  task automatic wdata(input logic [7:0] d);
    note(1'b0, 8'h01);
    u_m.byte_tx(d);
    if (!wp)
      mem[wptr] = d;
    wptr[4:0] = wptr[4:0] + 5'h01;
  endtask
  task automatic rd(input int n);
    ctl(1'b1, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      note(1'b1, mem[ptr]);
      u_m.byte_rx(i != n - 1);
      ptr = ptr + 12'h001;
    end
    u_m.stop();
  endtask
  // bounded wait, since a stuck busy would hang polling
  task automatic wait_free();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < WCYC + 200)
    begin
      @(negedge ref_clk);
      i++;
    end
    cmp_ack(1'b0, busy);
  endtask
  task automatic commit();
    u_m.stop();
    ctl(1'b0, 1'b0);
    u_m.stop();
    wait_free();
    ctl(1'b0, 1'b1);
    u_m.stop();
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    logic [7:0] v;
    sel = 3'($random(seed));
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int k = 0; k < 4; k++)
    begin
      v = {seep_pkg::TYPE_CODE, sel, 1'b0} ^ (k == 3 ? 8'h80 : 8'h02 << k);
      u_m.start();
      note(1'b0, 8'h00);
      u_m.byte_tx(v);
      u_m.stop();
    end
    $display("done: addressing");
    set_addr(12'hFFF);
    wdata(8'($random(seed)));
    commit();
    $display("done: byte write");
    set_addr(12'h01E);
    for (int k = 0; k < 34; k++)
      wdata(8'($random(seed)));
    commit();
    $display("done: page write");
    set_addr(12'hFFF);
    rd(32);
    rd(1);
    $display("done: reads");
    u_m.start();
    for (int k = 0; k < 4; k++)
      u_m.xbit(1'b1, v[0]);
    wp = 1'b1;
    set_addr(12'h005);
    wdata(8'($random(seed)));
    u_m.stop();
    wait_free();
    wp = 1'b0;
    set_addr(12'h005);
    rd(1);
    $display("done: protect and restart");
    conclude();
  end
endmodule
bind seep_slave seep_slave_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .select_pin_bit0_i(select_pin_bit0_i),
  .select_pin_bit1_i(select_pin_bit1_i),
  .select_pin_bit2_i(select_pin_bit2_i),
  .wp_i(wp_i),
  .busy_o(busy_o)
);
